// File: core/rpc_power_ctrl.sv
`timescale 1ns/10ps
module rpc_power_ctrl #(
   parameter int unsigned DEEP_CYC = rpc_pkg::DEEP_CYC_DEF
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic clk_en_i,
   input wire logic chan_enable_i,
   input wire logic far_load_probe_enable_i,
   input wire logic [1:0] sig_detect_i,
   input wire logic [1:0] load_found_i,
   input wire logic [1:0] probe_done_i,
   input wire rpc_pkg::rpc_cfg_s chan_a_sel_i,
   input wire rpc_pkg::rpc_cfg_s chan_b_sel_i,
   output rpc_pkg::rpc_term_s [1:0] term_o,
   output rpc_pkg::rpc_state_e [1:0] state_o,
   output rpc_pkg::rpc_cfg_s chan_a_cfg_o,
   output rpc_pkg::rpc_cfg_s chan_b_cfg_o
);
   // ==========================================
   // pin synchronisers
   logic [5:0] s1_q, s1_d, s2_q, s2_d;
   logic en_s, pe_s;
   logic [1:0] sd_s, ld_s, pd_s;

   always_comb
   begin
      s1_d = {chan_enable_i, far_load_probe_enable_i, sig_detect_i,
              load_found_i};
      s2_d = s1_q;
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         s1_q <= 6'h00;
         s2_q <= 6'h00;
      end
      else if (clk_en_i)
      begin
         s1_q <= s1_d;
         s2_q <= s2_d;
      end
   end

   // probe completion is generated on our clock by the analog sequencer
   assign pd_s = probe_done_i;
   assign {en_s, pe_s, sd_s, ld_s} = s2_q;

   // ==========================================
   // mode to termination
   function automatic rpc_pkg::rpc_term_s term_of(rpc_pkg::rpc_state_e s);
      rpc_pkg::rpc_term_s t;
      t.rin = rpc_pkg::RPC_RIN_50_VDD;
      t.rout = rpc_pkg::RPC_ROUT_50_VDD;
      t.out_active = 1'b0;
      t.probe_req = 1'b0;
      case (s)
         rpc_pkg::RPC_ST_PD:
         begin
            t.rin = rpc_pkg::RPC_RIN_67K_GND;
            t.rout = rpc_pkg::RPC_ROUT_HIZ;
         end
         rpc_pkg::RPC_ST_UNPLUG:
         begin
            t.rin = rpc_pkg::RPC_RIN_67K_RXBIAS;
            t.rout = rpc_pkg::RPC_ROUT_6K_TXBIAS;
            t.probe_req = 1'b1;
         end
         rpc_pkg::RPC_ST_PROBE:
         begin
            t.rout = rpc_pkg::RPC_ROUT_6K_VDD;
            t.probe_req = 1'b1;
         end
         rpc_pkg::RPC_ST_DEEP: t.rout = rpc_pkg::RPC_ROUT_6K_TXBIAS;
         rpc_pkg::RPC_ST_SLUMBER: t.rout = rpc_pkg::RPC_ROUT_6K_VDD;
         rpc_pkg::RPC_ST_ACTIVE: t.out_active = 1'b1;
         default: t.rout = rpc_pkg::RPC_ROUT_HIZ;
      endcase
      return t;
   endfunction

   // ==========================================
   // counters hold at full scale so a long idle never looks short again
   function automatic logic [rpc_pkg::CNT_W-1:0] sat_inc(
      input logic [rpc_pkg::CNT_W-1:0] v);
      return (&v) ? v : v + rpc_pkg::CNT_ONE;
   endfunction

   // ==========================================
   // per-channel machines, no cross terms
   rpc_pkg::rpc_state_e [1:0] st_q, st_d;
   logic [1:0][rpc_pkg::CNT_W-1:0] idle_q, idle_d, per_q, per_d;
   rpc_pkg::rpc_term_s [1:0] term_q, term_d;
   rpc_pkg::rpc_cfg_s cfg_a_q, cfg_b_q;

   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         st_d[c] = st_q[c];
         idle_d[c] = sd_s[c] ? rpc_pkg::CNT_ZERO : sat_inc(idle_q[c]);
         per_d[c] = sat_inc(per_q[c]);
         if (!en_s)
         begin
            st_d[c] = rpc_pkg::RPC_ST_PD;
            per_d[c] = rpc_pkg::CNT_ZERO;
         end
         else
         begin
            case (st_q[c])
               rpc_pkg::RPC_ST_PD:
               begin
                  // restart from detection, or straight to slumber
                  st_d[c] = pe_s ? rpc_pkg::RPC_ST_PROBE
                                 : rpc_pkg::RPC_ST_SLUMBER;
                  per_d[c] = rpc_pkg::CNT_ZERO;
               end
               rpc_pkg::RPC_ST_PROBE:
                  if (!pe_s)
                     st_d[c] = rpc_pkg::RPC_ST_SLUMBER;
                  else if (pd_s[c])
                  begin
                     st_d[c] = ld_s[c] ? rpc_pkg::RPC_ST_SLUMBER
                                       : rpc_pkg::RPC_ST_UNPLUG;
                     per_d[c] = rpc_pkg::CNT_ZERO;
                  end
               rpc_pkg::RPC_ST_UNPLUG:
                  // probing repeats continuously here
                  if (!pe_s || (pd_s[c] && ld_s[c]))
                  begin
                     st_d[c] = rpc_pkg::RPC_ST_SLUMBER;
                     per_d[c] = rpc_pkg::CNT_ZERO;
                  end
               rpc_pkg::RPC_ST_ACTIVE:
                  if (idle_q[c] > rpc_pkg::CNT_W'(rpc_pkg::SLUMBER_CYC))
                  begin
                     st_d[c] = rpc_pkg::RPC_ST_SLUMBER;
                     per_d[c] = rpc_pkg::CNT_ZERO;
                  end
               default: // slumber and deep slumber
               begin
                  if (sd_s[c])
                     st_d[c] = rpc_pkg::RPC_ST_ACTIVE;
                  else if (pe_s && (per_q[c] >=
                           rpc_pkg::CNT_W'(rpc_pkg::PROBE_CYC)))
                     st_d[c] = rpc_pkg::RPC_ST_PROBE;
                  else if (st_q[c] == rpc_pkg::RPC_ST_SLUMBER &&
                           idle_q[c] > rpc_pkg::CNT_W'(DEEP_CYC))
                     st_d[c] = rpc_pkg::RPC_ST_DEEP;
               end
            endcase
         end
         term_d[c] = term_of(st_d[c]);
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         for (int c = 0; c < 2; c++)
         begin
            st_q[c] <= rpc_pkg::RPC_ST_PD;
            idle_q[c] <= rpc_pkg::CNT_ZERO;
            per_q[c] <= rpc_pkg::CNT_ZERO;
            term_q[c] <= term_of(rpc_pkg::RPC_ST_PD);
         end
      end
      else if (clk_en_i)
      begin
         st_q <= st_d;
         idle_q <= idle_d;
         per_q <= per_d;
         term_q <= term_d;
      end
   end

   // ==========================================
   // strap settings, one copy per channel
   // straps are pins too, so they cross two stages like the other pins except probe_done_i
   localparam rpc_pkg::rpc_cfg_s CFG_RST = '{rpc_pkg::RPC_LVL_FLOAT,
      rpc_pkg::RPC_LVL_FLOAT, rpc_pkg::RPC_LVL_FLOAT};
   rpc_pkg::rpc_cfg_s cfg_a_m_q, cfg_a_m_d, cfg_b_m_q, cfg_b_m_d;
   rpc_pkg::rpc_cfg_s cfg_a_d, cfg_b_d;

   always_comb
   begin
      cfg_a_m_d = chan_a_sel_i;
      cfg_b_m_d = chan_b_sel_i;
      cfg_a_d = cfg_a_m_q;
      cfg_b_d = cfg_b_m_q;
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         cfg_a_m_q <= CFG_RST;
         cfg_b_m_q <= CFG_RST;
         cfg_a_q <= CFG_RST;
         cfg_b_q <= CFG_RST;
      end
      else if (clk_en_i)
      begin
         cfg_a_m_q <= cfg_a_m_d;
         cfg_b_m_q <= cfg_b_m_d;
         cfg_a_q <= cfg_a_d;
         cfg_b_q <= cfg_b_d;
      end
   end

   assign term_o = term_q;
   assign state_o = st_q;
   assign chan_a_cfg_o = cfg_a_q;
   assign chan_b_cfg_o = cfg_b_q;

   // ==========================================
   // checks
   // one clock domain, so clock and reset are given once here
   default clocking chk_cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);

   pd_forced_a: assert property (
      clk_en_i && !en_s |=> st_q[0] == rpc_pkg::RPC_ST_PD)
      else $error("channel 0 not in power-down");
   slumber_time_a: assert property (
      $changed(st_q[0]) && st_q[0] == rpc_pkg::RPC_ST_SLUMBER &&
      $past(st_q[0]) == rpc_pkg::RPC_ST_ACTIVE |->
      $past(idle_q[0]) > rpc_pkg::CNT_W'(rpc_pkg::SLUMBER_CYC))
      else $error("slumber entered early");
   wake_fast_a: assert property (
      clk_en_i && en_s && sd_s[0] &&
      (st_q[0] == rpc_pkg::RPC_ST_SLUMBER ||
      st_q[0] == rpc_pkg::RPC_ST_DEEP) |=>
      st_q[0] == rpc_pkg::RPC_ST_ACTIVE)
      else $error("low-power channel did not wake");
   probe_gap_a: assert property (
      st_q[0] == rpc_pkg::RPC_ST_PROBE &&
      ($past(st_q[0]) == rpc_pkg::RPC_ST_SLUMBER ||
      $past(st_q[0]) == rpc_pkg::RPC_ST_DEEP) |->
      $past(per_q[0]) >= rpc_pkg::CNT_W'(rpc_pkg::PROBE_CYC))
      else $error("probe restarted early");
   no_load_a: assert property (
      clk_en_i && en_s && pe_s && st_q[1] == rpc_pkg::RPC_ST_PROBE &&
      pd_s[1] && !ld_s[1] |=> st_q[1] == rpc_pkg::RPC_ST_UNPLUG)
      else $error("unplug not entered");
   load_back_a: assert property (
      clk_en_i && en_s && pe_s && st_q[0] == rpc_pkg::RPC_ST_PROBE &&
      pd_s[0] && ld_s[0] |=> st_q[0] == rpc_pkg::RPC_ST_SLUMBER)
      else $error("load found but slumber not resumed");
   pd_term_a: assert property (
      st_q[0] == rpc_pkg::RPC_ST_PD |->
      term_o[0].rin == rpc_pkg::RPC_RIN_67K_GND &&
      term_o[0].rout == rpc_pkg::RPC_ROUT_HIZ)
      else $error("power-down termination wrong");
   unplug_term_a: assert property (
      st_q[1] == rpc_pkg::RPC_ST_UNPLUG |->
      term_o[1].rin == rpc_pkg::RPC_RIN_67K_RXBIAS &&
      term_o[1].rout == rpc_pkg::RPC_ROUT_6K_TXBIAS)
      else $error("unplug termination wrong");
   active_out_a: assert property (
      term_o[0].out_active == (st_q[0] == rpc_pkg::RPC_ST_ACTIVE))
      else $error("output enable disagrees with mode");
   no_probe_a: assert property (
      clk_en_i && !pe_s && en_s && st_q[0] != rpc_pkg::RPC_ST_PD
      |=> st_q[0] != rpc_pkg::RPC_ST_PROBE &&
      st_q[0] != rpc_pkg::RPC_ST_UNPLUG)
      else $error("probe while disabled");
   deep_entry_a: assert property (
      $changed(st_q[1]) && st_q[1] == rpc_pkg::RPC_ST_DEEP |->
      $past(st_q[1]) == rpc_pkg::RPC_ST_SLUMBER &&
      $past(idle_q[1]) > rpc_pkg::CNT_W'(DEEP_CYC))
      else $error("deep slumber entered early");
   cfg_follow_a: assert property (
      clk_en_i ##1 clk_en_i |=> chan_b_cfg_o == $past(chan_b_sel_i, 2))
      else $error("channel b setting not applied");
   state_hold_a: assert property (
      !clk_en_i |=> $stable(st_q) && $stable(idle_q) && $stable(per_q))
      else $error("state moved while clock enable low");

   cov_slumber_c: cover property (st_q[0] == rpc_pkg::RPC_ST_SLUMBER);
   cov_unplug_c: cover property (st_q[1] == rpc_pkg::RPC_ST_UNPLUG);
   cov_deep_c: cover property (st_q[0] == rpc_pkg::RPC_ST_DEEP);
   cov_wake_c: cover property (
      $past(st_q[0]) == rpc_pkg::RPC_ST_DEEP &&
      st_q[0] == rpc_pkg::RPC_ST_ACTIVE);
   cov_reprobe_c: cover property (
      $past(st_q[0]) == rpc_pkg::RPC_ST_DEEP &&
      st_q[0] == rpc_pkg::RPC_ST_PROBE);
endmodule

// File: dv/rpc_far_model.sv
`timescale 1ns/10ps
// ==========================================
// far-end load probe responder
module rpc_far_model (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [1:0] probe_req_i,
   input wire logic [1:0] load_present_i,
   output logic [1:0] load_found_o,
   output logic [1:0] probe_done_o
);
   logic [2:0] cnt_q [2];
   always_ff @(posedge mclk_i)
   begin
      for (int c = 0; c < 2; c++)
      begin
         if (!rst_b_i)
         begin
            cnt_q[c] <= 3'h0;
            load_found_o[c] <= 1'b0;
            probe_done_o[c] <= 1'b0;
         end
         else
         begin
            // keeps probing while asked, so unplug repeats
            if (cnt_q[c] != 3'h0 || probe_req_i[c])
               cnt_q[c] <= (cnt_q[c] == 3'h5) ? 3'h0 : cnt_q[c] + 3'h1;
            // result held stable 3 edges before the pulse
            if (cnt_q[c] == 3'h0 && probe_req_i[c])
               load_found_o[c] <= load_present_i[c];
            else if (cnt_q[c] == 3'h5)
               load_found_o[c] <= ~load_found_o[c]; // stale after use
            probe_done_o[c] <= (cnt_q[c] == 3'h3);
         end
      end
   end
endmodule

// File: dv/rpc_power_ctrl_tb.sv
`timescale 1ns/10ps
module rpc_power_ctrl_tb;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic chan_enable = 1'b1;
   logic probe_enable = 1'b1;
   logic clk_en = 1'b1;
   logic [1:0] sig = 2'h0;
   logic [1:0] load_present = 2'h1;
   logic [1:0] found;
   logic [1:0] done;
   rpc_pkg::rpc_cfg_s cfg_a = 6'h00;
   rpc_pkg::rpc_cfg_s cfg_b = 6'h00;
   rpc_pkg::rpc_cfg_s cfg_a_o;
   rpc_pkg::rpc_cfg_s cfg_b_o;
   rpc_pkg::rpc_term_s [1:0] term;
   rpc_pkg::rpc_state_e [1:0] state;
   wire logic [1:0] preq = {term[1].probe_req, term[0].probe_req};
   int n_errors = 0;
   int total_checks = 0;

   always #50 mclk_i = ~mclk_i;

   // deep slumber shortened to keep the run small
   rpc_power_ctrl #(.DEEP_CYC(200)) u_dut (.mclk_i(mclk_i),
      .rst_b_i(rst_b_i), .clk_en_i(clk_en), .chan_enable_i(chan_enable),
      .far_load_probe_enable_i(probe_enable), .sig_detect_i(sig),
      .load_found_i(found), .probe_done_i(done), .chan_a_sel_i(cfg_a),
      .chan_b_sel_i(cfg_b), .term_o(term), .state_o(state),
      .chan_a_cfg_o(cfg_a_o), .chan_b_cfg_o(cfg_b_o));

   rpc_far_model u_far (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
      .probe_req_i(preq), .load_present_i(load_present),
      .load_found_o(found), .probe_done_o(done));

   // ==========================================
   // checking
   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask

   task automatic chk_st(input int c, input rpc_pkg::rpc_state_e s);
      chk($sformatf("state%0d", c), {2'h0, state[c]}, {2'h0, s});
   endtask

   task automatic chk_tm(input int c, input logic [5:0] t);
      chk($sformatf("term%0d", c), {2'h0, term[c]}, {2'h0, t});
   endtask

   // bounded wait; running out ends the run
   task automatic wait_st(input int c, input rpc_pkg::rpc_state_e s,
                          input int lim);
      for (int i = 0; i < lim && state[c] !== s; i++)
         @(negedge mclk_i);
      chk_st(c, s);
      if (state[c] !== s)
         test_done();
   endtask

   // ==========================================
   // tests
   initial
   begin
      cyc(16);
      chk_st(0, rpc_pkg::RPC_ST_PD);
      chk_tm(1, 6'h20);
      chk("cfg_a", {2'h0, cfg_a_o}, 8'h2A);
      rst_b_i = 1'b1;
      wait_st(0, rpc_pkg::RPC_ST_PROBE, 10);
      wait_st(0, rpc_pkg::RPC_ST_SLUMBER, 20);
      chk_tm(0, 6'h08);
      wait_st(1, rpc_pkg::RPC_ST_UNPLUG, 20);
      chk("rin_rout1", {4'h0, term[1].rin, term[1].rout}, 8'h05);
      $display("test probe done");
      for (int k = 0; k < 4; k++)
      begin
         cfg_a = {3{2'(k)}};
         cfg_b = {3{2'(3 - k)}};
         cyc(4);
         chk("cfg_a", {2'h0, cfg_a_o}, {2'h0, {3{2'(k)}}});
         chk("cfg_b", {2'h0, cfg_b_o}, {2'h0, {3{2'(3 - k)}}});
      end
      $display("test straps done");
      sig[0] = 1'b1;
      wait_st(0, rpc_pkg::RPC_ST_ACTIVE, 6);
      chk_tm(0, 6'h0E);
      chk_st(1, rpc_pkg::RPC_ST_UNPLUG);
      load_present[1] = 1'b1;
      wait_st(1, rpc_pkg::RPC_ST_SLUMBER, 20);
      cyc(300);
      chk_st(1, rpc_pkg::RPC_ST_DEEP);
      chk_tm(1, 6'h04);
      chk_st(0, rpc_pkg::RPC_ST_ACTIVE);
      $display("test wake done");
      sig[0] = 1'b0;
      cyc(12990);
      chk_st(0, rpc_pkg::RPC_ST_ACTIVE);
      wait_st(0, rpc_pkg::RPC_ST_SLUMBER, 20);
      cyc(59980);
      chk_st(0, rpc_pkg::RPC_ST_DEEP);
      wait_st(0, rpc_pkg::RPC_ST_PROBE, 40);
      wait_st(0, rpc_pkg::RPC_ST_SLUMBER, 20);
      sig[0] = 1'b1;
      wait_st(0, rpc_pkg::RPC_ST_ACTIVE, 6);
      $display("test idle done");
      clk_en = 1'b0;
      chan_enable = 1'b0;
      cyc(6);
      chk_st(0, rpc_pkg::RPC_ST_ACTIVE);
      clk_en = 1'b1;
      wait_st(0, rpc_pkg::RPC_ST_PD, 6);
      chk_st(1, rpc_pkg::RPC_ST_PD);
      chk_tm(1, 6'h20);
      probe_enable = 1'b0;
      sig = 2'h0;
      chan_enable = 1'b1;
      wait_st(1, rpc_pkg::RPC_ST_SLUMBER, 8);
      chk("probe_req", {6'h00, preq}, 8'h00);
      cyc(10);
      chk_st(1, rpc_pkg::RPC_ST_DEEP);
      chk("probe_req", {6'h00, preq}, 8'h00);
      $display("test power down done");
      test_done();
   end
endmodule

// File: include/rpc_pkg.sv
package rpc_pkg;
   // ==========================================
   // timing
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam real IDLE_TO_SLUMBER_MS = 1.3;
   localparam real SLUMBER_PROBE_MS = 6.0;
   localparam real TOTAL_PROBE_MS = 7.3;
   localparam int unsigned SLUMBER_CYC =
      int'(IDLE_TO_SLUMBER_MS * CLK_HZ / 1000.0);
   localparam int unsigned PROBE_CYC =
      int'(SLUMBER_PROBE_MS * CLK_HZ / 1000.0);
   localparam int unsigned TOTAL_CYC =
      int'(TOTAL_PROBE_MS * CLK_HZ / 1000.0);
   localparam int unsigned DEEP_CYC_DEF = 20_000;
   localparam int unsigned CNT_W = 20;
   localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
   localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;

   // ==========================================
   // four-level strap codes
   typedef enum logic [1:0] {
      RPC_LVL_LOW = 2'h0,
      RPC_LVL_RES = 2'h1,
      RPC_LVL_FLOAT = 2'h2,
      RPC_LVL_HIGH = 2'h3
   } rpc_lvl_e;

   typedef struct packed {
      rpc_lvl_e flat_gain;
      rpc_lvl_e swing;
      rpc_lvl_e equalizer;
   } rpc_cfg_s;

   // ==========================================
   // channel modes, one-hot
   typedef enum logic [5:0] {
      RPC_ST_PD = 6'h01,
      RPC_ST_PROBE = 6'h02,
      RPC_ST_UNPLUG = 6'h04,
      RPC_ST_DEEP = 6'h08,
      RPC_ST_SLUMBER = 6'h10,
      RPC_ST_ACTIVE = 6'h20
   } rpc_state_e;

   typedef enum logic [1:0] {
      RPC_RIN_50_VDD = 2'h0,
      RPC_RIN_67K_RXBIAS = 2'h1,
      RPC_RIN_67K_GND = 2'h2
   } rpc_rin_e;

   typedef enum logic [1:0] {
      RPC_ROUT_HIZ = 2'h0,
      RPC_ROUT_6K_TXBIAS = 2'h1,
      RPC_ROUT_6K_VDD = 2'h2,
      RPC_ROUT_50_VDD = 2'h3
   } rpc_rout_e;

   typedef struct packed {
      rpc_rin_e rin;
      rpc_rout_e rout;
      logic out_active;
      logic probe_req;
   } rpc_term_s;
endpackage
